// ### shared/dgs_params.svh
// Register indices, reset values and gain-step figures for the gain and swap-ramp block
`ifndef DGS_PARAMS_SVH
`define DGS_PARAMS_SVH
`define DGS_IDX_SWAP_CTRL 8'h5B
`define DGS_IDX_IN_1L 8'hF4
`define DGS_IDX_IN_1R 8'hF5
`define DGS_IDX_IN_2L 8'hF6
`define DGS_IDX_IN_2R 8'hF7
`define DGS_IDX_OUT_1L 8'hF8
`define DGS_IDX_OUT_1R 8'hF9
`define DGS_IDX_SWAP_STATUS 8'hFA
`define DGS_GAIN_RESET 8'h6F
`define DGS_SUBR_BIT 6
`define DGS_RAMP_BIT 5
`define DGS_STEPS_RESET 5'h14
`define DGS_CTRL_RESET 8'h74
`define DGS_SUBSTEPS_PER_STEP 7'h03
`define DGS_FINE_STEP 7'h01
`define DGS_MAX_LEVEL 7'h5D
`define DGS_RESP_OKAY 2'h0
`define DGS_RESP_SLVERR 2'h2
`endif

// ### shared/dgs_pkg.sv
// Types shared by the gain and swap-ramp block
package dgs_pkg;
    typedef struct packed {
        logic [6:0] one_left;
        logic [6:0] one_right;
        logic [6:0] two_left;
        logic [6:0] two_right;
    } input_levels_t;
    typedef struct packed {
        logic [7:0] one_left;
        logic [7:0] one_right;
    } output_levels_t;
    typedef enum logic [3:0] {
        SEL_NONE, SEL_SWAP_CTRL, SEL_IN_1L, SEL_IN_1R, SEL_IN_2L, SEL_IN_2R,
        SEL_OUT_1L, SEL_OUT_1R, SEL_SWAP_STATUS
    } reg_sel_t;
    typedef enum {SWAP_OFF, SWAP_RAMP, SWAP_FULL} swap_state_t;
endpackage

// ### hw/digital_gain_and_swap_ramp_control.sv
// Digital gain registers and DAC gain-swap step engine behind an AXI4-Lite slave
//
// Notes on behaviour
// [RULE1] Input gain 7 bits, -83.25 to +12 dB
// [RULE2] Four input gains, each only its channel
// [RULE3] Output gain 8 bits, -83.25 to +108 dB
// [RULE4] All gain fields reset to 0x6F
// [RULE5] Ramp off jumps, ramp on 1.5 dB
// [RULE6] Sub-range gives 0.5 dB steps when ramping
// [RULE7] Five-bit step limit, 1.5 dB units, 0x14
// [RULE8] Ramp and sub-range enabled at reset
// [RULE9] Apply below trigger, drop all on anticlip
// [RULE10] New gain applied at next sample boundary
`timescale 1ns/1ps
`include "dgs_params.svh"
module digital_gain_and_swap_ramp_control (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic record_sample_strobe,
    input wire logic playback_sample_strobe,
    input wire logic below_trigger,
    input wire logic above_anticlip,
    output dgs_pkg::input_levels_t input_levels,
    output dgs_pkg::output_levels_t output_levels,
    output logic [6:0] swap_level,
    output logic swap_active
);
    import dgs_pkg::*;

    // Map a byte address onto a register; byte addresses sit at four times their index
    function automatic reg_sel_t decode(input logic [11:0] addr);
        reg_sel_t sel;
        sel = SEL_NONE;
        if (addr[1:0] == 2'h0) begin
            case (addr[9:2])
                `DGS_IDX_SWAP_CTRL: sel = SEL_SWAP_CTRL;
                `DGS_IDX_IN_1L: sel = SEL_IN_1L;
                `DGS_IDX_IN_1R: sel = SEL_IN_1R;
                `DGS_IDX_IN_2L: sel = SEL_IN_2L;
                `DGS_IDX_IN_2R: sel = SEL_IN_2R;
                `DGS_IDX_OUT_1L: sel = SEL_OUT_1L;
                `DGS_IDX_OUT_1R: sel = SEL_OUT_1R;
                `DGS_IDX_SWAP_STATUS: sel = SEL_SWAP_STATUS;
                default: sel = SEL_NONE;
            endcase
        end
        if (addr[11:10] != 2'h0) begin
            sel = SEL_NONE;
        end
        return sel;
    endfunction

    logic [7:0] swap_ctrl; // Sub-range, ramp enable, step limit
    logic [6:0] in_gain [4]; // Staged input gains, order 1L 1R 2L 2R
    logic [7:0] out_gain [2]; // Staged output gains, order 1L 1R
    logic aw_held; // Write address captured
    logic w_held; // Write data captured
    logic [11:0] aw_addr; // Captured write address
    logic [31:0] w_data; // Captured write data
    logic [3:0] w_strb; // Captured byte enables
    logic do_write; // Both halves present, response slot free
    reg_sel_t wsel; // Decoded write target
    reg_sel_t rsel; // Decoded read target
    swap_state_t swap_state; // Gain-swap engine state
    logic [6:0] swap_target; // Limit in 0.5 dB sub-steps
    logic [6:0] swap_incr; // Ramp increment in sub-steps
    logic [6:0] next_swap_level; // Level after the next playback sample

    assign do_write = aw_held && w_held && !s_axi_bvalid;
    assign wsel = decode(aw_addr);
    assign rsel = decode(s_axi_araddr);

    // Write address channel; ready drops once an address is held
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held <= 1'b0;
            aw_addr <= 12'h000;
            s_axi_awready <= 1'b0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end else if (do_write) begin
            aw_held <= 1'b0;
            s_axi_awready <= 1'b1;
        end else begin
            s_axi_awready <= !aw_held;
        end
    end

    // Write data channel, independent of the address so either may come first
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held <= 1'b0;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            s_axi_wready <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end else if (do_write) begin
            w_held <= 1'b0;
            s_axi_wready <= 1'b1;
        end else begin
            s_axi_wready <= !w_held;
        end
    end

    // Write response; unmapped addresses answer SLVERR and store nothing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `DGS_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= (wsel == SEL_NONE) ? `DGS_RESP_SLVERR : `DGS_RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Swap control register; only byte lane 0 carries data
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_ctrl <= `DGS_CTRL_RESET; // RULE8
        end else if (do_write && w_strb[0] && wsel == SEL_SWAP_CTRL) begin
            swap_ctrl <= {1'b0, w_data[6:0]}; // RULE7
        end
    end

    // Staged gains; software writes land here, the datapath sees them later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            for (int i = 0; i < 4; i++) begin
                in_gain[i] <= 7'(`DGS_GAIN_RESET); // RULE4
            end
            for (int j = 0; j < 2; j++) begin
                out_gain[j] <= `DGS_GAIN_RESET; // RULE4
            end
        end else if (do_write && w_strb[0]) begin
            case (wsel)
                SEL_IN_1L: in_gain[0] <= w_data[6:0]; // RULE1 RULE2
                SEL_IN_1R: in_gain[1] <= w_data[6:0]; // RULE2
                SEL_IN_2L: in_gain[2] <= w_data[6:0]; // RULE2
                SEL_IN_2R: in_gain[3] <= w_data[6:0]; // RULE2
                SEL_OUT_1L: out_gain[0] <= w_data[7:0]; // RULE3
                SEL_OUT_1R: out_gain[1] <= w_data[7:0]; // RULE3
                default: ;
            endcase
        end
    end

    // Read channel; one read in flight, answered the cycle after acceptance
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `DGS_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= (rsel == SEL_NONE) ? `DGS_RESP_SLVERR : `DGS_RESP_OKAY;
            case (rsel)
                SEL_SWAP_CTRL: s_axi_rdata <= {24'h00_0000, swap_ctrl};
                SEL_IN_1L: s_axi_rdata <= {25'h000_0000, in_gain[0]};
                SEL_IN_1R: s_axi_rdata <= {25'h000_0000, in_gain[1]};
                SEL_IN_2L: s_axi_rdata <= {25'h000_0000, in_gain[2]};
                SEL_IN_2R: s_axi_rdata <= {25'h000_0000, in_gain[3]};
                SEL_OUT_1L: s_axi_rdata <= {24'h00_0000, out_gain[0]};
                SEL_OUT_1R: s_axi_rdata <= {24'h00_0000, out_gain[1]};
                SEL_SWAP_STATUS: s_axi_rdata <= {24'h00_0000, swap_active, swap_level};
                default: s_axi_rdata <= 32'h0000_0000;
            endcase
        end else if (s_axi_rvalid) begin
            s_axi_rvalid <= !s_axi_rready;
            s_axi_arready <= s_axi_rready;
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Record-path gains move only on a sample boundary, never mid-sample
    generate
        for (genvar g = 0; g < 4; g++) begin : gen_in_apply
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    input_levels[27 - 7 * g -: 7] <= 7'(`DGS_GAIN_RESET); // RULE4
                end else if (record_sample_strobe) begin
                    input_levels[27 - 7 * g -: 7] <= in_gain[g]; // RULE10 RULE2
                end
            end
        end
    endgenerate

    // Playback-path gains, same boundary discipline
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            output_levels <= {`DGS_GAIN_RESET, `DGS_GAIN_RESET}; // RULE4
        end else if (playback_sample_strobe) begin
            output_levels <= {out_gain[0], out_gain[1]}; // RULE10 RULE3
        end
    end

    // Step limit counts whole 1.5 dB steps; level counts 0.5 dB sub-steps
    always_comb begin
        swap_target = 7'(swap_ctrl[4:0] * `DGS_SUBSTEPS_PER_STEP); // RULE7
        swap_incr = swap_ctrl[`DGS_SUBR_BIT] ? `DGS_FINE_STEP : `DGS_SUBSTEPS_PER_STEP; // RULE6 RULE5
        next_swap_level = swap_level;
        if (!below_trigger) begin
            next_swap_level = (swap_level > swap_target) ? swap_target : swap_level;
        end else if (!swap_ctrl[`DGS_RAMP_BIT]) begin
            next_swap_level = swap_target; // RULE5
        end else if (swap_level >= swap_target || swap_target - swap_level <= swap_incr) begin
            next_swap_level = swap_target; // RULE5 RULE6
        end else begin
            next_swap_level = swap_level + swap_incr; // RULE5 RULE6
        end
    end

    // Swap engine; anticlip drops every step at once, not waiting for a sample
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_level <= 7'h00;
            swap_state <= SWAP_OFF;
        end else if (above_anticlip) begin
            swap_level <= 7'h00; // RULE9
            swap_state <= SWAP_OFF;
        end else if (playback_sample_strobe) begin
            swap_level <= next_swap_level; // RULE9
            case (swap_state)
                SWAP_OFF: swap_state <= (next_swap_level != 7'h00) ? SWAP_RAMP : SWAP_OFF;
                SWAP_RAMP: swap_state <= (next_swap_level == swap_target) ? SWAP_FULL : SWAP_RAMP;
                SWAP_FULL: swap_state <= (next_swap_level == swap_target) ? SWAP_FULL : SWAP_RAMP;
                default: swap_state <= SWAP_OFF;
            endcase
        end
    end

    // Active flag registered so it leaves the block straight from a flop
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            swap_active <= 1'b0;
        end else begin
            swap_active <= (swap_state != SWAP_OFF);
        end
    end

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_in_gain_width: assert property (do_write && w_strb[0] && wsel == SEL_IN_1L |=> // RULE1
        in_gain[0] == $past(w_data[6:0]) && in_gain[1] == $past(in_gain[1])) else $error("input gain write wrong");
    a_in_channel_own: assert property (record_sample_strobe |=> // RULE2
        input_levels.two_right == $past(in_gain[3])) else $error("input gain not on own channel");
    a_out_gain_width: assert property (do_write && w_strb[0] && wsel == SEL_OUT_1R |=> // RULE3
        out_gain[1] == $past(w_data[7:0])) else $error("output gain write wrong");
    a_gain_reset_val: assert property (!$past(aresetn) |-> // RULE4
        out_gain[0] == `DGS_GAIN_RESET && input_levels.one_left == 7'h6F) else $error("gain reset value wrong");
    a_ramp_off_jump: assert property (playback_sample_strobe && below_trigger && !above_anticlip // RULE5
        && !swap_ctrl[`DGS_RAMP_BIT] |=> swap_level == $past(swap_target)) else $error("unramped step not immediate");
    a_fine_step_size: assert property (playback_sample_strobe && below_trigger && !above_anticlip // RULE6
        && swap_ctrl[5] && swap_ctrl[6] |=> swap_level <= $past(swap_level) + 7'h01) else $error("sub-step too large");
    // Each sample must leave the level within the programmed step limit, not just the absolute ceiling
    a_level_bound: assert property (playback_sample_strobe && !above_anticlip |=> // RULE7
        swap_level <= $past(swap_target) && swap_level <= `DGS_MAX_LEVEL) else $error("swap level beyond limit");
    a_ctrl_reset: assert property (!$past(aresetn) |-> swap_ctrl == 8'h74) else $error("swap control reset wrong"); // RULE8
    a_anticlip_drop: assert property (above_anticlip |=> swap_level == 7'h00 ##1 !swap_active) else $error("anticlip not immediate"); // RULE9
    a_apply_boundary: assert property ($changed(output_levels) |-> $past(playback_sample_strobe)) else $error("gain changed mid-sample"); // RULE10
endmodule

// ### bench/tb.sv
// Self-checking bench for the gain registers and swap step engine
`timescale 1ns/1ps
`include "dgs_params.svh"
module tb;
    import dgs_pkg::*;
    logic aclk = 1'b0; // 50 MHz system clock
    logic aresetn = 1'b0; // Held low for two edges
    logic [11:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, swap_active;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic record_sample_strobe = 0, playback_sample_strobe = 0, below_trigger = 0, above_anticlip = 0;
    input_levels_t input_levels;
    output_levels_t output_levels;
    logic [6:0] swap_level;
    int failures = 0, n_compared = 0;
    logic [31:0] rd; // Last read data
    logic [1:0] rr; // Last read response
    // Free-running clock
    always #10 aclk = ~aclk;
    digital_gain_and_swap_ramp_control dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready), .record_sample_strobe(record_sample_strobe),
        .playback_sample_strobe(playback_sample_strobe), .below_trigger(below_trigger),
        .above_anticlip(above_anticlip), .input_levels(input_levels), .output_levels(output_levels),
        .swap_level(swap_level), .swap_active(swap_active));
    // Byte address is four times the register index
    function automatic logic [11:0] addr_of(input logic [7:0] idx);
        return {2'b00, idx, 2'b00};
    endfunction
    // Single comparison point, four-state exact
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // Verdict and end of run
    task automatic tally_and_finish;
        if (failures == 0 && n_compared > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // Write with address and data offered together, each released once taken
    task automatic axi_write(input logic [11:0] a, input logic [31:0] d, input logic [1:0] exp_resp);
        logic aw_done, w_done, b_done;
        aw_done = 0;
        w_done = 0;
        b_done = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_awvalid <= 1;
        s_axi_wdata <= d;
        s_axi_wstrb <= 4'hF;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        // Wait for the answer; only the watchdog ends a slave that never answers
        while (!b_done) begin
            @(posedge aclk);
            if (!aw_done && s_axi_awready) begin
                aw_done = 1;
                s_axi_awvalid <= 0;
            end
            if (!w_done && s_axi_wready) begin
                w_done = 1;
                s_axi_wvalid <= 0;
            end
            if (s_axi_bvalid) begin
                s_axi_bready <= 0;
                check(s_axi_bresp, exp_resp);
                b_done = 1;
            end
        end
    endtask
    // Read one word; rready stays up until rvalid is seen
    task automatic axi_read(input logic [11:0] a);
        logic r_done;
        r_done = 0;
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        // No cycle count assumed; a hang is left to the watchdog
        while (!r_done) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 0;
            end
            if (s_axi_rvalid) begin
                rd = s_axi_rdata;
                rr = s_axi_rresp;
                s_axi_rready <= 0;
                r_done = 1;
            end
        end
    endtask
    // One-cycle sample boundary pulse, then let the update land
    task automatic pulse(input bit playback);
        @(posedge aclk);
        if (playback) playback_sample_strobe <= 1;
        else record_sample_strobe <= 1;
        @(posedge aclk);
        playback_sample_strobe <= 0;
        record_sample_strobe <= 0;
        repeat (2) @(posedge aclk);
    endtask
    // Reset defaults of the gain and swap control registers and of the gain level outputs
    task automatic test_reset_values;
        for (int i = 0; i < 6; i++) begin
            axi_read(addr_of(`DGS_IDX_IN_1L + i));
            check(rd, 32'h0000006F);
        end
        axi_read(addr_of(`DGS_IDX_SWAP_CTRL));
        check(rd, 32'h00000074);
        check(input_levels, {4{7'h6F}});
        check(output_levels, {2{8'h6F}});
    endtask
    // Distinct gains per channel, held back until the sample boundary
    task automatic test_gains;
        logic [7:0] val [6] = '{8'h00, 8'h7F, 8'hC5, 8'h12, 8'hFF, 8'h00};
        for (int i = 0; i < 6; i++) axi_write(addr_of(`DGS_IDX_IN_1L + i), {24'h0, val[i]}, `DGS_RESP_OKAY);
        for (int i = 0; i < 4; i++) begin
            axi_read(addr_of(`DGS_IDX_IN_1L + i));
            check(rd, {25'h0, val[i][6:0]});
        end
        axi_read(addr_of(`DGS_IDX_OUT_1L));
        check(rd, 32'h000000FF);
        check(input_levels, {4{7'h6F}});
        pulse(0);
        check(input_levels, {7'h00, 7'h7F, 7'h45, 7'h12});
        check(output_levels, {2{8'h6F}});
        pulse(1);
        check(output_levels, 16'hFF00);
        check(swap_level, 7'h00);
        check(swap_active, 1'b0);
    endtask
    // Unmapped address is refused and reads back as zero
    task automatic test_unmapped;
        axi_write(12'h004, 32'h000000AA, `DGS_RESP_SLVERR);
        axi_read(12'h004);
        check(rd, 32'h0);
        check(rr, `DGS_RESP_SLVERR);
    endtask
    // Program the step control, then walk the swap level through strobes
    task automatic swap_run(input logic [7:0] ctrl, input int n_strobes, input int step);
        axi_write(addr_of(`DGS_IDX_SWAP_CTRL), {24'h0, ctrl}, `DGS_RESP_OKAY);
        for (int k = 1; k <= n_strobes; k++) begin
            pulse(1);
            check(swap_level, (k * step < 6) ? k * step : 6);
        end
        // Engine is applying steps; status shows the flag over the level
        check(swap_active, 1'b1);
        axi_read(addr_of(`DGS_IDX_SWAP_STATUS));
        check(rd, 32'h00000086);
        // Anticlip drops every step at once
        @(posedge aclk);
        above_anticlip <= 1;
        @(posedge aclk);
        above_anticlip <= 0;
        repeat (2) @(posedge aclk);
        check(swap_level, 7'h00);
        check(swap_active, 1'b0);
    endtask
    // Two-step limit: jump, coarse ramp, fine ramp, fine ignored without ramp
    task automatic test_swap;
        below_trigger <= 1;
        swap_run(8'h02, 1, 6);
        swap_run(8'h22, 3, 3);
        swap_run(8'h62, 7, 1);
        swap_run(8'h42, 1, 6);
        axi_read(addr_of(`DGS_IDX_SWAP_CTRL));
        check(rd, 32'h00000042);
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        test_reset_values();
        test_gains();
        test_unmapped();
        test_swap();
        tally_and_finish();
    end
    // Watchdog, well beyond the expected run length
    initial begin
        #200000;
        failures++;
        tally_and_finish();
    end
endmodule
